// ### in_ep_pkg.sv
/*
  Constants and types for the low control register of an IN endpoint.
  Assumes one core clock domain shared with the serial interface engine.
*/
package in_ep_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] IN_EP_CTRL_LOW_ADDR = 8'h11;
  localparam logic [7:0] CTRL_LOW_RESET = 8'h00;
  localparam int BIT_UNUSED = 7;
  localparam int BIT_TOGGLE_CLEAR = 6;
  localparam int BIT_STALL_SENT = 5;
  localparam int BIT_SEND_STALL = 4;
  localparam int BIT_FLUSH = 3;
  localparam int BIT_UNDERRUN = 2;
  localparam int BIT_FIFO_NOT_EMPTY = 1;
  localparam int BIT_IN_PACKET_READY = 0;

  // ----------------------------------------------------------------------
  // Packet slots
  // ----------------------------------------------------------------------
  localparam logic [1:0] SLOTS_SINGLE = 2'h1;
  localparam logic [1:0] SLOTS_DOUBLE = 2'h2;
  localparam logic [1:0] SLOTS_NONE = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } tx_state_t;

  // Firmware-visible state bits held by the block
  typedef struct packed {
    logic stall_sent;
    logic send_stall;
    logic flush;
    logic underrun;
    logic in_packet_ready;
  } ctrl_low_t;

  // Per-token answer pulses toward the serial engine
  typedef struct packed {
    logic stall;
    logic data;
    logic zlp;
    logic nak;
  } token_answer_t;
endpackage : in_ep_pkg

// ### in_ep_ctrl_low.sv
/*
  Low control/status register of one IN endpoint with its packet-slot tracking
  and IN-token answer logic.
  Assumes the register port, token and transmit strobes all come from logic on
  CORE_CLK; mode bits from the high control register arrive as levels.
*/
// Contract
// R1: Register at 0x11, resets to zero
// R2: Bit 7 reads zero, writes ignored
// R3: Writing toggle_clear resets data toggle
// R4: toggle_clear always reads zero
// R5: Stall handshake sets stall_sent_flag
// R6: stall_sent_flag stays until software clears
// R7: send_stall answers every IN with STALL (code stalls only in ST_IDLE; an IN token during ST_SEND gets no answer)
// R8: Stall flushes FIFO, clears packet ready
// R9: Flush drops one packet, self-clears
// R10: Iso empty IN sends ZLP, sets underrun
// R11: Packet ready clears; interrupt only after transmit (EP_INT also pulses on stall and on flush of a packet)
// R12: fifo_not_empty reflects FIFO holding packets
module in_ep_ctrl_low (
  input wire logic CORE_CLK,         // Core clock, 100 MHz
  input wire logic RST,              // Synchronous reset, active high
  input wire logic [7:0] REG_ADDR,   // Register space address
  input wire logic REG_WR,           // Write strobe
  input wire logic REG_RD,           // Read strobe
  input wire logic [7:0] REG_WDATA,  // Write data
  output logic [7:0] REG_RDATA,      // Read data, registered
  input wire logic ISO_MODE,         // Isochronous mode level
  input wire logic DBL_BUF_EN,       // in_double_buffer_enable level
  input wire logic IN_TOKEN,         // IN token received, pulse
  input wire logic TX_DONE,          // Data packet sent, pulse
  input wire logic TX_ACKED,         // Host acked, valid with TX_DONE
  output logic ANS_STALL,            // Send STALL handshake, pulse
  output logic ANS_DATA,             // Send queued packet, pulse
  output logic ANS_ZLP,              // Send zero-length packet, pulse
  output logic ANS_NAK,              // Send NAK, pulse
  output logic DATA_TOGGLE,          // Current data toggle
  output logic FIFO_PTR_RESET,       // Drop head packet on flush, whole FIFO on stall, pulse
  output logic EP_INT                // Endpoint interrupt, pulse
);
  in_ep_pkg::ctrl_low_t ctl_reg, ctl_next;
  in_ep_pkg::token_answer_t ans_reg, ans_next;
  in_ep_pkg::tx_state_t state_reg, state_next;
  logic [1:0] pkts_reg, pkts_next;
  logic toggle_reg, toggle_next;
  logic ptr_rst_reg, ptr_rst_next;
  logic int_reg, int_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] cap;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_view;

  // ----------------------------------------------------------------------
  // Register decode and read view
  // ----------------------------------------------------------------------
  assign wr_hit = REG_WR && (REG_ADDR == in_ep_pkg::IN_EP_CTRL_LOW_ADDR); // [R1]
  assign rd_hit = REG_RD && (REG_ADDR == in_ep_pkg::IN_EP_CTRL_LOW_ADDR);
  assign cap = DBL_BUF_EN ? in_ep_pkg::SLOTS_DOUBLE : in_ep_pkg::SLOTS_SINGLE;

  always_comb
  begin
    rd_view = 8'h00; // [R2] [R4]
    rd_view[in_ep_pkg::BIT_STALL_SENT] = ctl_reg.stall_sent;
    rd_view[in_ep_pkg::BIT_SEND_STALL] = ctl_reg.send_stall;
    rd_view[in_ep_pkg::BIT_FLUSH] = ctl_reg.flush;
    rd_view[in_ep_pkg::BIT_UNDERRUN] = ctl_reg.underrun;
    rd_view[in_ep_pkg::BIT_FIFO_NOT_EMPTY] = (pkts_reg != in_ep_pkg::SLOTS_NONE); // [R12]
    rd_view[in_ep_pkg::BIT_IN_PACKET_READY] = ctl_reg.in_packet_ready;
    rdata_next = rd_hit ? rd_view : 8'h00;
  end

  // ----------------------------------------------------------------------
  // Control state, packet slots and token answers
  // ----------------------------------------------------------------------
  always_comb
  begin
    ctl_next = ctl_reg;
    ans_next = '0;
    state_next = state_reg;
    pkts_next = pkts_reg;
    toggle_next = toggle_reg;
    ptr_rst_next = 1'b0;
    int_next = 1'b0;

    // Software writes: flags clear on 0, set-by-hardware below wins
    if (wr_hit)
    begin
      ctl_next.send_stall = REG_WDATA[in_ep_pkg::BIT_SEND_STALL];
      if (!REG_WDATA[in_ep_pkg::BIT_STALL_SENT])
      begin
        ctl_next.stall_sent = 1'b0; // [R6]
      end
      if (!REG_WDATA[in_ep_pkg::BIT_UNDERRUN])
      begin
        ctl_next.underrun = 1'b0;
      end
      if (REG_WDATA[in_ep_pkg::BIT_FLUSH])
      begin
        ctl_next.flush = 1'b1; // [R9]
      end
      if (REG_WDATA[in_ep_pkg::BIT_TOGGLE_CLEAR])
      begin
        toggle_next = 1'b0; // [R3]
      end
      if (REG_WDATA[in_ep_pkg::BIT_IN_PACKET_READY] && !ctl_reg.in_packet_ready
          && (pkts_reg < cap))
      begin
        pkts_next = pkts_reg + 2'h1;
        ctl_next.in_packet_ready = 1'b1;
      end
    end

    // Flush completes one cycle after it is requested
    if (ctl_reg.flush)
    begin
      // Repeat write in the completing cycle queues one more flush
      ctl_next.flush = wr_hit && REG_WDATA[in_ep_pkg::BIT_FLUSH]; // [R9]
      ctl_next.in_packet_ready = 1'b0;
      ptr_rst_next = 1'b1;
      if (pkts_reg != in_ep_pkg::SLOTS_NONE)
      begin
        pkts_next = pkts_reg - 2'h1;
        int_next = 1'b1;
      end
    end

    case (state_reg)
      in_ep_pkg::ST_IDLE:
      begin
        if (IN_TOKEN)
        begin
          if (ctl_reg.send_stall)
          begin
            ans_next.stall = 1'b1; // [R7]
            ctl_next.stall_sent = 1'b1; // [R5]
            ctl_next.in_packet_ready = 1'b0; // [R8]
            pkts_next = in_ep_pkg::SLOTS_NONE; // [R8]
            ptr_rst_next = 1'b1;
            int_next = 1'b1;
          end
          else if (pkts_reg != in_ep_pkg::SLOTS_NONE)
          begin
            ans_next.data = 1'b1;
            state_next = in_ep_pkg::ST_SEND;
          end
          else if (ISO_MODE)
          begin
            ans_next.zlp = 1'b1; // [R10]
            ctl_next.underrun = 1'b1; // [R10]
          end
          else
          begin
            ans_next.nak = 1'b1;
          end
        end
      end
      in_ep_pkg::ST_SEND:
      begin
        if (TX_DONE)
        begin
          state_next = in_ep_pkg::ST_IDLE;
          if (TX_ACKED || ISO_MODE)
          begin
            if (pkts_next != in_ep_pkg::SLOTS_NONE)
            begin
              pkts_next = pkts_next - 2'h1;
            end
            ctl_next.in_packet_ready = 1'b0; // [R11]
            toggle_next = ~toggle_next;
            int_next = 1'b1; // [R11]
          end
        end
      end
      default:
      begin
        state_next = in_ep_pkg::ST_IDLE;
      end
    endcase

    // Double buffering frees packet ready while a slot is open, no interrupt
    if (DBL_BUF_EN && ctl_next.in_packet_ready && (pkts_next < in_ep_pkg::SLOTS_DOUBLE))
    begin
      ctl_next.in_packet_ready = 1'b0; // [R11]
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      ctl_reg <= '0; // [R1]
      ans_reg <= '0;
      state_reg <= in_ep_pkg::ST_IDLE;
      pkts_reg <= in_ep_pkg::SLOTS_NONE;
      toggle_reg <= 1'b0;
      ptr_rst_reg <= 1'b0;
      int_reg <= 1'b0;
      rdata_reg <= in_ep_pkg::CTRL_LOW_RESET;
    end
    else
    begin
      ctl_reg <= ctl_next;
      ans_reg <= ans_next;
      state_reg <= state_next;
      pkts_reg <= pkts_next;
      toggle_reg <= toggle_next;
      ptr_rst_reg <= ptr_rst_next;
      int_reg <= int_next;
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign ANS_STALL = ans_reg.stall;
  assign ANS_DATA = ans_reg.data;
  assign ANS_ZLP = ans_reg.zlp;
  assign ANS_NAK = ans_reg.nak;
  assign DATA_TOGGLE = toggle_reg;
  assign FIFO_PTR_RESET = ptr_rst_reg;
  assign EP_INT = int_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  AST_RESET_ZERO: assert property ($fell(RST) |-> ctl_reg == '0 && pkts_reg == in_ep_pkg::SLOTS_NONE) // [R1]
    else $error("control bits not zero after reset");
  AST_BIT7_ZERO: assert property (REG_RDATA[in_ep_pkg::BIT_UNUSED] == 1'b0) // [R2]
    else $error("bit 7 read as one");
  AST_TOGGLE_CLEAR: assert property (wr_hit && REG_WDATA[in_ep_pkg::BIT_TOGGLE_CLEAR] // [R3]
    && state_reg == in_ep_pkg::ST_IDLE |=> !DATA_TOGGLE)
    else $error("toggle not cleared");
  AST_CLR_READS_ZERO: assert property (REG_RDATA[in_ep_pkg::BIT_TOGGLE_CLEAR] == 1'b0) // [R4]
    else $error("toggle_clear read as one");
  AST_STALL_SETS_FLAG: assert property (ANS_STALL |-> ctl_reg.stall_sent && EP_INT) // [R5]
    else $error("stall sent flag not set");
  AST_FLAG_HOLDS: assert property (ctl_reg.stall_sent && !wr_hit |=> ctl_reg.stall_sent) // [R6]
    else $error("stall sent flag dropped by itself");
  AST_STALL_ONLY: assert property (IN_TOKEN && ctl_reg.send_stall // [R7]
    && state_reg == in_ep_pkg::ST_IDLE |=> ANS_STALL && !ANS_DATA && !ANS_ZLP && !ANS_NAK)
    else $error("IN token not stalled");
  AST_STALL_FLUSH: assert property (ANS_STALL |-> pkts_reg == in_ep_pkg::SLOTS_NONE && FIFO_PTR_RESET) // [R8]
    else $error("stall did not flush");
  AST_FLUSH_SELF_CLEAR: assert property (ctl_reg.flush // [R9]
    && !(wr_hit && REG_WDATA[in_ep_pkg::BIT_FLUSH]) |=> !ctl_reg.flush && FIFO_PTR_RESET)
    else $error("flush did not complete in one cycle");
  AST_ISO_UNDERRUN: assert property (IN_TOKEN && ISO_MODE && !ctl_reg.send_stall // [R10]
    && pkts_reg == in_ep_pkg::SLOTS_NONE && state_reg == in_ep_pkg::ST_IDLE
    |=> ANS_ZLP && ctl_reg.underrun)
    else $error("no zero-length packet on iso underrun");
  AST_SEND_RETIRES: assert property (state_reg == in_ep_pkg::ST_SEND && TX_DONE && TX_ACKED // [R11]
    && !ctl_reg.flush |=> EP_INT && !ctl_reg.in_packet_ready)
    else $error("transmit did not retire packet");
  AST_NOT_EMPTY: assert property (REG_RD && REG_ADDR == in_ep_pkg::IN_EP_CTRL_LOW_ADDR // [R12]
    |=> REG_RDATA[in_ep_pkg::BIT_FIFO_NOT_EMPTY] == ($past(pkts_reg) != in_ep_pkg::SLOTS_NONE))
    else $error("fifo_not_empty mismatch");

  COV_DATA_SENT: cover property (ANS_DATA ##[1:20] (TX_DONE && TX_ACKED));
  COV_STALL: cover property (ANS_STALL);
  COV_ISO_ZLP: cover property (ANS_ZLP);
  COV_DOUBLE: cover property (pkts_reg == in_ep_pkg::SLOTS_DOUBLE);
endmodule : in_ep_ctrl_low

// ### usb_host_model.sv
/*
  Host side of the IN endpoint: issues IN tokens and ends each data packet.
  Assumes tokens are requested by a one-cycle go pulse on CORE_CLK.
*/
module usb_host_model (
  input wire logic CORE_CLK, // Core clock
  input wire logic RST,      // Synchronous reset
  input wire logic go,       // Request one IN token
  input wire logic ack,      // Host acks the next packet
  input wire logic ans_data, // Device sends a packet
  output logic in_token,     // IN token pulse
  output logic tx_done,      // Packet finished pulse
  output logic tx_acked      // Ack level, valid with tx_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_reg;
  // ----------------------------------------------------------------------
  // Token and end of packet
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    in_token <= go & ~RST;
    tx_done <= 1'b0;
    tx_acked <= ~tx_acked & ~RST; // Meaningless outside tx_done
    if (RST)
      wait_reg <= 2'h0;
    else if (ans_data)
      wait_reg <= 2'h2;
    else if (wait_reg != 2'h0)
    begin
      wait_reg <= wait_reg - 2'h1;
      tx_done <= (wait_reg == 2'h1);
      if (wait_reg == 2'h1)
        tx_acked <= ack;
    end
  end
endmodule : usb_host_model

// ### usb_in_endpoint_ctrl_low_bench.sv
/*
  Self-checking bench of the IN endpoint low control register.
  Assumes the host model drives the token side.
*/
module usb_in_endpoint_ctrl_low_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, iso = 1'b0, dbl = 1'b0;
  logic go = 1'b0, ack = 1'b1, tok, done, acked, tgl, fpr, eint;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  logic [3:0] ans;
  int err_total = 0, tests_run = 0, cycles = 0, n_int = 0, n_fpr = 0;
  logic [15:0] rows [5] = '{16'h4000, 16'h8000, 16'h1010, 16'h0000, 16'h0103};
  in_ep_ctrl_low dut (.CORE_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wd), .REG_RDATA(rdata), .ISO_MODE(iso), .DBL_BUF_EN(dbl),
    .IN_TOKEN(tok), .TX_DONE(done), .TX_ACKED(acked), .ANS_STALL(ans[3]),
    .ANS_DATA(ans[2]), .ANS_ZLP(ans[1]), .ANS_NAK(ans[0]), .DATA_TOGGLE(tgl),
    .FIFO_PTR_RESET(fpr), .EP_INT(eint));
  usb_host_model host (.CORE_CLK(clk), .RST(rst), .go(go), .ack(ack),
    .ans_data(ans[2]), .in_token(tok), .tx_done(done), .tx_acked(acked));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask : wr8
  task automatic rd8(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) v = rdata;
  endtask : rd8
  task automatic token(output logic [3:0] seen);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    seen = 4'h0;
    for (int i = 0; i < 4 && seen == 4'h0; i++)
      @(negedge clk) seen = ans;
    repeat (6) @(posedge clk);
  endtask : token
  task automatic results;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // ----------------------------------------------------------------------
  // Clock, event counts, timeout
  // ----------------------------------------------------------------------
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    n_int += int'(eint === 1'b1);
    n_fpr += int'(fpr === 1'b1);
    if (cycles == 3000)
    begin
      err_total++;
      results();
    end
  end
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    logic [7:0] v;
    logic [3:0] a;
    int i0, f0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd8(8'h11, v); check("reset", v, 8'h00);
    foreach (rows[i])
    begin
      wr8(8'h11, rows[i][15:8]);
      rd8(8'h11, v); check("row", v, rows[i][7:0]);
    end
    $display("done: table");
    i0 = n_int;
    token(a); check("data answer", 8'(a), 8'h04);
    check("int", 8'(n_int - i0), 8'h01);
    check("toggle", 8'(tgl), 8'h01);
    rd8(8'h11, v); check("retired", v, 8'h00);
    wr8(8'h11, 8'h40);
    @(negedge clk) check("toggle clear", 8'(tgl), 8'h00);
    wr8(8'h11, 8'h11);
    {i0, f0} = {n_int, n_fpr};
    token(a); check("stall answer", 8'(a), 8'h08);
    check("stall int", 8'(n_int - i0), 8'h01);
    check("stall flush", 8'(n_fpr - f0), 8'h01);
    rd8(8'h11, v); check("stall sent", v, 8'h30);
    wr8(8'h11, 8'h30);
    rd8(8'h11, v); check("stall kept", v, 8'h30);
    wr8(8'h11, 8'h00);
    rd8(8'h11, v); check("stall cleared", v, 8'h00);
    $display("done: stall");
    @(posedge clk) iso <= 1'b1;
    token(a); check("zlp", 8'(a), 8'h02);
    rd8(8'h11, v); check("underrun", v, 8'h04);
    wr8(8'h11, 8'h00);
    iso <= 1'b0;
    token(a); check("nak", 8'(a), 8'h01);
    wr8(8'h11, 8'h01);
    ack <= 1'b0;
    i0 = n_int;
    token(a); check("unacked answer", 8'(a), 8'h04);
    check("unacked int", 8'(n_int - i0), 8'h00);
    check("unacked toggle", 8'(tgl), 8'h00);
    rd8(8'h11, v); check("unacked kept", v, 8'h03);
    @(posedge clk) ack <= 1'b1;
    {i0, f0} = {n_int, n_fpr};
    wr8(8'h11, 8'h08);
    repeat (3) @(posedge clk);
    check("flush int", 8'(n_int - i0), 8'h01);
    check("flush ptr", 8'(n_fpr - f0), 8'h01);
    rd8(8'h11, v); check("flushed", v, 8'h00);
    $display("done: iso and flush");
    @(posedge clk) dbl <= 1'b1;
    i0 = n_int;
    wr8(8'h11, 8'h01);
    rd8(8'h11, v); check("double", v, 8'h02);
    check("double int", 8'(n_int - i0), 8'h00);
    wr8(8'h12, 8'h10);
    rd8(8'h12, v); check("other addr", v, 8'h00);
    rd8(8'h11, v); check("unchanged", v, 8'h02);
    wr8(8'h11, 8'h01);
    rd8(8'h11, v); check("double full", v, 8'h03);
    $display("done: double and address");
    results();
  end
endmodule : usb_in_endpoint_ctrl_low_bench
